// ==== shared/giis_pkg.sv ====
`default_nettype none
package giis_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned GIIS_AW    = 12;
  localparam int unsigned GIIS_DW    = 32;
  localparam int unsigned GIIS_NPIN  = 12;   // event-capable pins
  localparam int unsigned GIIS_NIND  = 8;    // pins that can be indicators
  localparam int unsigned GIIS_FUNW  = 2;    // indicator function width

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] GIIS_OFS_IND_CFG   = 12'h1bc;
  localparam logic [11:0] GIIS_OFS_PIN_EVT   = 12'h1e8;
  localparam logic [11:0] GIIS_OFS_CHIP_STS  = 12'h058;
  localparam logic [11:0] GIIS_OFS_CHIP_EN   = 12'h05c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned GIIS_EVT_STS_LSB   = 0;    // status 11:0
  localparam int unsigned GIIS_EVT_EN_LSB    = 16;   // enable 27:16
  localparam int unsigned GIIS_IND_EN_LSB    = 0;    // enable 7:0
  localparam int unsigned GIIS_IND_FUN_LSB   = 8;    // function 9:8
  localparam int unsigned GIIS_CHIP_GPIO_BIT = 12;   // gpio summary
  localparam int unsigned GIIS_CHIP_LOAD_BIT = 0;    // loader wrote config
  localparam int unsigned GIIS_CHIP_STRP_BIT = 1;    // straps captured

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [11:0] GIIS_RST_PIN12     = 12'h000;
  localparam logic [7:0]  GIIS_RST_IND_EN    = 8'h00;
  localparam logic [1:0]  GIIS_RST_IND_FUN   = 2'h0;
  localparam logic [31:0] GIIS_RST_WORD      = 32'h0000_0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned GIIS_CLK_NS        = 20;   // pclk period
  localparam int unsigned GIIS_PERSIST_NS    = 40;   // least event width
  localparam int unsigned GIIS_PERSIST_CYC   = (GIIS_PERSIST_NS + GIIS_CLK_NS - 1) / GIIS_CLK_NS;
  localparam logic [1:0]  GIIS_PERSIST_CNT   = 2'(GIIS_PERSIST_CYC);
  localparam logic [1:0]  GIIS_STRAP_SETTLE  = 2'h3;  // cycles after release

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [2:0] {
    GIIS_BUS_IDLE = 3'b001,
    GIIS_BUS_WAIT = 3'b010,
    GIIS_BUS_RESP = 3'b100
  } giis_bus_st_t;

  typedef enum logic [2:0] {
    GIIS_STRAP_HOLD = 3'b001,
    GIIS_STRAP_LOAD = 3'b010,
    GIIS_STRAP_RUN  = 3'b100
  } giis_strap_st_t;

endpackage
`default_nettype wire

// ==== hdl/giis_event_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module giis_event_filter
  import giis_pkg::*;
(
  input  wire logic                 pclk,        // system clock
  input  wire logic                 presetn,     // async reset, low
  input  wire logic [GIIS_NPIN-1:0] pin_level,   // raw pin levels
  output logic      [GIIS_NPIN-1:0] recognised   // persistent high level
);

  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  logic [GIIS_NPIN-1:0] meta;
  logic [GIIS_NPIN-1:0] sync;
  logic [1:0]           run [GIIS_NPIN];

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= GIIS_RST_PIN12;
      sync <= GIIS_RST_PIN12;
    end else begin
      meta <= pin_level;
      sync <= meta;
    end
  end

  // ****************************************************************
  // persistence counter per pin
  // ****************************************************************
  // a level counts only after more than the least width of samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recognised <= GIIS_RST_PIN12;
      for (int i = 0; i < GIIS_NPIN; i++) run[i] <= 2'h0;
    end else begin
      for (int i = 0; i < GIIS_NPIN; i++) begin
        if (!sync[i]) begin
          run[i]        <= 2'h0;
          recognised[i] <= 1'b0;
        end else if (run[i] == GIIS_PERSIST_CNT) begin
          recognised[i] <= 1'b1;
        end else begin
          run[i]        <= run[i] + 2'h1;
          recognised[i] <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/giis_pin_route.sv ====
`timescale 1ns/1ps
`default_nettype none
module giis_pin_route
  import giis_pkg::*;
(
  input  wire logic                 pclk,          // system clock
  input  wire logic                 presetn,       // async reset, low
  input  wire logic [GIIS_NIND-1:0] ind_enable,    // indicator enable per pin
  input  wire logic [GIIS_FUNW-1:0] ind_function,  // opaque function code
  input  wire logic [GIIS_NIND-1:0] gpio_drive,    // ordinary gpio output
  input  wire logic [GIIS_NIND-1:0] ind_drive,     // mapped indicator level
  output logic      [GIIS_NIND-1:0] pin_drive,     // level toward the pin
  output logic      [GIIS_FUNW-1:0] fun_out        // code toward the mapper
);

  // ****************************************************************
  // per-pin source select
  // ****************************************************************
  // function code is forwarded untouched; its meaning lives in the mapper
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_drive <= GIIS_RST_IND_EN;
      fun_out   <= GIIS_RST_IND_FUN;
    end else begin
      fun_out   <= ind_function;
      pin_drive <= (ind_enable & ind_drive) | (~ind_enable & gpio_drive);
    end
  end

endmodule
`default_nettype wire

// ==== hdl/giis_top.sv ====
// Behaviour
// - writing one to a pin event status bit clears it; zero leaves it.
// - enabled pin event status bits OR into chip status bit 12.
// - each of twelve enable bits admits its pin into the summary.
// - status bits record events whether or not their enable is set.
// - interrupt output asserts for gpio only if chip enable bit 12 set.
// - twelve status bits; status and enable fields reset to zero.
// - event inputs are levels; must persist beyond 40 ns to count.
// - indicator enable bit routes its pin to indicator, else gpio.
// - two-bit function selects indicator behaviour for enabled pins only.
// - indicator fields default from straps caught at reset release.
// - configuration loader may overwrite strap defaults after reset.
// - reserved bits read as zero and ignore writes; chip enable bits 11:2 take writes and read back.
`timescale 1ns/1ps
`default_nettype none
module giis_top
  import giis_pkg::*;
(
  input  wire logic                 pclk,                     // system clock
  input  wire logic                 presetn,                  // async reset, low
  input  wire logic [GIIS_AW-1:0]   paddr,                    // apb address
  input  wire logic                 psel,                     // apb select
  input  wire logic                 penable,                  // apb enable
  input  wire logic                 pwrite,                   // apb direction
  input  wire logic [GIIS_DW-1:0]   pwdata,                   // apb write data
  output logic      [GIIS_DW-1:0]   prdata,                   // apb read data
  output logic                      pready,                   // apb ready
  output logic                      pslverr,                  // apb error
  input  wire logic [GIIS_NPIN-1:0] gpio_event_in,            // event pins, async
  input  wire logic                 pin_reset_n,              // reset pin, async
  input  wire logic [GIIS_NIND-1:0] indicator_enable_strap,   // strap, async
  input  wire logic [GIIS_FUNW-1:0] indicator_function_strap, // strap, async
  input  wire logic                 loader_valid,             // loader write strobe
  input  wire logic [GIIS_NIND-1:0] loader_ind_enable,        // loader enable value
  input  wire logic [GIIS_FUNW-1:0] loader_ind_function,      // loader function value
  input  wire logic [GIIS_NIND-1:0] gpio_drive,               // gpio output data
  input  wire logic [GIIS_NIND-1:0] indicator_drive,          // mapper output levels
  output logic      [GIIS_NIND-1:0] pin_drive,                // routed pin level
  output logic      [GIIS_FUNW-1:0] indicator_function_select,// code to mapper
  output logic      [GIIS_NIND-1:0] indicator_pin_enable,     // indicator enables
  output logic                      irq                       // level interrupt
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // sticky update: a set in the same cycle as a clear wins
  function automatic logic [GIIS_NPIN:0] sticky(
    input logic [GIIS_NPIN:0] cur,
    input logic [GIIS_NPIN:0] set,
    input logic [GIIS_NPIN:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  // address match for a completing write
  function automatic logic wr_hit(
    input logic             commit,
    input logic             is_wr,
    input logic [11:0]      addr,
    input logic [11:0]      ofs
  );
    wr_hit = commit && is_wr && (addr == ofs);
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  giis_bus_st_t         bus_st;
  giis_strap_st_t       strap_st;
  logic [GIIS_NPIN-1:0] evt_status;      // pin event status 11:0
  logic [GIIS_NPIN-1:0] evt_enable;      // pin event enable 27:16
  logic [GIIS_NIND-1:0] ind_enable;      // indicator enable 7:0
  logic [GIIS_FUNW-1:0] ind_function;    // indicator function 9:8
  logic [GIIS_NPIN:0]   chip_sticky;     // chip status sticky bits
  logic [GIIS_NPIN:0]   chip_enable;     // chip interrupt mask
  logic [GIIS_NPIN-1:0] recognised;      // filtered event levels
  logic [GIIS_NIND-1:0] strap_en_m;
  logic [GIIS_NIND-1:0] strap_en_s;
  logic [GIIS_FUNW-1:0] strap_fun_m;
  logic [GIIS_FUNW-1:0] strap_fun_s;
  logic                 prst_m;
  logic                 prst_s;
  logic [1:0]           settle;
  logic                 commit;
  logic                 gpio_summary;
  logic [GIIS_NPIN:0]   chip_view;
  logic [GIIS_NPIN:0]   chip_set;
  logic [GIIS_NPIN:0]   chip_clr;
  logic                 wr_evt;
  logic                 wr_ind;
  logic                 wr_csts;
  logic                 wr_cen;
  logic                 strap_load;
  logic                 addr_ok;
  logic [GIIS_DW-1:0]   next_rdata;

  // ****************************************************************
  // event input filtering
  // ****************************************************************
  giis_event_filter u_filter (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_level  (gpio_event_in),
    .recognised (recognised)
  );

  // ****************************************************************
  // pin and strap synchronisers
  // ****************************************************************
  // first stages are read by the second stages only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prst_m      <= 1'b0;
      prst_s      <= 1'b0;
      strap_en_m  <= GIIS_RST_IND_EN;
      strap_en_s  <= GIIS_RST_IND_EN;
      strap_fun_m <= GIIS_RST_IND_FUN;
      strap_fun_s <= GIIS_RST_IND_FUN;
    end else begin
      prst_m      <= pin_reset_n;
      prst_s      <= prst_m;
      strap_en_m  <= indicator_enable_strap;
      strap_en_s  <= strap_en_m;
      strap_fun_m <= indicator_function_strap;
      strap_fun_s <= strap_fun_m;
    end
  end

  // ****************************************************************
  // strap capture sequence
  // ****************************************************************
  // waits for the synchronisers to settle after either reset lets go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_st <= GIIS_STRAP_HOLD;
      settle   <= 2'h0;
    end else begin
      case (strap_st)
        GIIS_STRAP_HOLD: begin
          if (!prst_s) begin
            settle <= 2'h0;
          end else if (settle == GIIS_STRAP_SETTLE) begin
            strap_st <= GIIS_STRAP_LOAD;
          end else begin
            settle <= settle + 2'h1;
          end
        end
        GIIS_STRAP_LOAD: begin
          strap_st <= GIIS_STRAP_RUN;
        end
        GIIS_STRAP_RUN: begin
          if (!prst_s) begin
            strap_st <= GIIS_STRAP_HOLD;
            settle   <= 2'h0;
          end
        end
        default: begin
          strap_st <= GIIS_STRAP_HOLD;
          settle   <= 2'h0;
        end
      endcase
    end
  end

  assign strap_load = (strap_st == GIIS_STRAP_LOAD);

  // ****************************************************************
  // apb slave sequence
  // ****************************************************************
  // two wait cycles after penable rises, then pready for one cycle; writes commit with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_st  <= GIIS_BUS_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= GIIS_RST_WORD;
    end else begin
      case (bus_st)
        GIIS_BUS_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && penable) begin
            bus_st <= GIIS_BUS_WAIT;
          end
        end
        GIIS_BUS_WAIT: begin
          bus_st  <= GIIS_BUS_RESP;
          pready  <= 1'b1;
          pslverr <= !addr_ok;
          prdata  <= pwrite ? GIIS_RST_WORD : next_rdata;
        end
        GIIS_BUS_RESP: begin
          bus_st  <= GIIS_BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
          prdata  <= GIIS_RST_WORD;
        end
        default: begin
          bus_st  <= GIIS_BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
          prdata  <= GIIS_RST_WORD;
        end
      endcase
    end
  end

  assign commit  = (bus_st == GIIS_BUS_RESP) && psel && penable;
  assign addr_ok = (paddr == GIIS_OFS_IND_CFG) || (paddr == GIIS_OFS_PIN_EVT) ||
                   (paddr == GIIS_OFS_CHIP_STS) || (paddr == GIIS_OFS_CHIP_EN);
  assign wr_evt  = wr_hit(commit, pwrite, paddr, GIIS_OFS_PIN_EVT);
  assign wr_ind  = wr_hit(commit, pwrite, paddr, GIIS_OFS_IND_CFG);
  assign wr_csts = wr_hit(commit, pwrite, paddr, GIIS_OFS_CHIP_STS);
  assign wr_cen  = wr_hit(commit, pwrite, paddr, GIIS_OFS_CHIP_EN);

  // ****************************************************************
  // read data assembly
  // ****************************************************************
  // unlisted bits stay zero and never take write data
  always_comb begin
    next_rdata = GIIS_RST_WORD;
    case (paddr)
      GIIS_OFS_PIN_EVT: begin
        next_rdata[GIIS_EVT_STS_LSB +: GIIS_NPIN] = evt_status;
        next_rdata[GIIS_EVT_EN_LSB +: GIIS_NPIN]  = evt_enable;
      end
      GIIS_OFS_IND_CFG: begin
        next_rdata[GIIS_IND_EN_LSB +: GIIS_NIND]  = ind_enable;
        next_rdata[GIIS_IND_FUN_LSB +: GIIS_FUNW] = ind_function;
      end
      GIIS_OFS_CHIP_STS: begin
        next_rdata[GIIS_NPIN:0] = chip_view;
      end
      GIIS_OFS_CHIP_EN: begin
        next_rdata[GIIS_NPIN:0] = chip_enable;
      end
      default: begin
        next_rdata = GIIS_RST_WORD;
      end
    endcase
  end

  // ****************************************************************
  // pin event status and enable
  // ****************************************************************
  // status latches the filtered source regardless of enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= GIIS_RST_PIN12;
      evt_enable <= GIIS_RST_PIN12;
    end else if (!prst_s) begin
      evt_status <= GIIS_RST_PIN12;
      evt_enable <= GIIS_RST_PIN12;
    end else begin
      if (wr_evt) begin
        evt_status <= (evt_status & ~pwdata[GIIS_EVT_STS_LSB +: GIIS_NPIN]) | recognised;
        evt_enable <= pwdata[GIIS_EVT_EN_LSB +: GIIS_NPIN];
      end else begin
        evt_status <= evt_status | recognised;
      end
    end
  end

  // ****************************************************************
  // indicator configuration
  // ****************************************************************
  // strap capture first, then loader, then software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_enable   <= GIIS_RST_IND_EN;
      ind_function <= GIIS_RST_IND_FUN;
    end else if (strap_load) begin
      ind_enable   <= strap_en_s;
      ind_function <= strap_fun_s;
    end else if (loader_valid && strap_st == GIIS_STRAP_RUN) begin
      ind_enable   <= loader_ind_enable;
      ind_function <= loader_ind_function;
    end else if (wr_ind) begin
      ind_enable   <= pwdata[GIIS_IND_EN_LSB +: GIIS_NIND];
      ind_function <= pwdata[GIIS_IND_FUN_LSB +: GIIS_FUNW];
    end
  end

  // ****************************************************************
  // chip level status and mask
  // ****************************************************************
  // summary is a live cascade; the other bits are sticky events
  assign gpio_summary = |(evt_status & evt_enable);

  always_comb begin
    chip_set = '0;
    chip_clr = '0;
    chip_set[GIIS_CHIP_LOAD_BIT] = loader_valid && (strap_st == GIIS_STRAP_RUN);
    chip_set[GIIS_CHIP_STRP_BIT] = strap_load;
    if (wr_csts) begin
      chip_clr = pwdata[GIIS_NPIN:0];
    end
    chip_clr[GIIS_CHIP_GPIO_BIT] = 1'b0;
    chip_view = chip_sticky;
    chip_view[GIIS_CHIP_GPIO_BIT] = gpio_summary;
  end

  // sticky bits, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sticky <= '0;
    end else begin
      chip_sticky <= sticky(chip_sticky, chip_set, chip_clr);
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_enable <= '0;
    end else if (wr_cen) begin
      chip_enable <= pwdata[GIIS_NPIN:0];
    end
  end

  // level interrupt, gated by the chip mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(chip_view & chip_enable);
    end
  end

  // ****************************************************************
  // indicator output registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_pin_enable <= GIIS_RST_IND_EN;
    end else begin
      indicator_pin_enable <= ind_enable;
    end
  end

  giis_pin_route u_route (
    .pclk         (pclk),
    .presetn      (presetn),
    .ind_enable   (ind_enable),
    .ind_function (ind_function),
    .gpio_drive   (gpio_drive),
    .ind_drive    (indicator_drive),
    .pin_drive    (pin_drive),
    .fun_out      (indicator_function_select)
  );

endmodule
`default_nettype wire

// ==== sim/giis_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module giis_top_assertions
  import giis_pkg::*;
(
  input wire logic                 pclk,                      // clock
  input wire logic                 presetn,                   // reset
  input wire logic [GIIS_AW-1:0]   paddr,                     // address
  input wire logic                 psel,                      // select
  input wire logic                 penable,                   // enable
  input wire logic                 pwrite,                    // direction
  input wire logic [GIIS_DW-1:0]   pwdata,                    // wdata
  input wire logic [GIIS_DW-1:0]   prdata,                    // rdata
  input wire logic                 pready,                    // ready
  input wire logic                 pslverr,                   // error
  input wire logic [GIIS_NIND-1:0] gpio_drive,                // gpio data
  input wire logic [GIIS_NIND-1:0] indicator_drive,           // mapper
  input wire logic [GIIS_NIND-1:0] pin_drive,                 // routed
  input wire logic [GIIS_FUNW-1:0] indicator_function_select, // code
  input wire logic [GIIS_NIND-1:0] indicator_pin_enable,      // enables
  input wire logic                 irq                        // interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [GIIS_DW-1:0] mask_q;
  logic               hit;
  // address decode seen from the bus
  assign hit = paddr inside {GIIS_OFS_IND_CFG, GIIS_OFS_PIN_EVT, GIIS_OFS_CHIP_STS, GIIS_OFS_CHIP_EN};
  // shadow of the chip mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (psel && penable && pready && pwrite && paddr == GIIS_OFS_CHIP_EN) begin
      mask_q <= pwdata;
    end
  end
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 !pready ##1 pready)
    else $error("wrong answer time");
  chk_err_unmapped: assert property (pready |-> pslverr == !hit)
    else $error("error flag wrong");
  chk_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data not idle");
  chk_rsvd_event: assert property (pready && !pwrite && paddr == GIIS_OFS_PIN_EVT |->
    prdata[31:28] == '0 && prdata[15:12] == '0) else $error("event reserved bits set");
  chk_ind_read: assert property (pready && !pwrite && paddr == GIIS_OFS_IND_CFG |->
    prdata == {22'h0, indicator_function_select, indicator_pin_enable}) else $error("indicator read wrong");
  chk_irq_gate: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !irq)
    else $error("irq while masked");
  chk_pin_route: assert property ($past(presetn) |-> pin_drive ==
    ((indicator_pin_enable & $past(indicator_drive)) | (~indicator_pin_enable & $past(gpio_drive))))
    else $error("pin routing wrong");
endmodule
bind giis_top giis_top_assertions giis_top_assertions_inst (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .gpio_drive, .indicator_drive, .pin_drive,
  .indicator_function_select, .indicator_pin_enable, .irq);
`default_nettype wire

// ==== sim/giis_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module giis_pin_model
  import giis_pkg::*;
(
  input  wire logic                 pclk,                      // clock
  input  wire logic [GIIS_FUNW-1:0] indicator_function_select, // code
  output logic      [GIIS_NIND-1:0] indicator_drive,           // lamp levels
  output logic      [GIIS_NPIN-1:0] gpio_event_in              // event levels
);
  // mapper stand-in: each code gives its own lamp pattern
  assign indicator_drive = {4{indicator_function_select}};
  initial gpio_event_in = '0;
  // hold event levels for a count of cycles, then drop them
  task automatic pulse(input logic [GIIS_NPIN-1:0] m, input int cyc);
    @(posedge pclk);
    gpio_event_in <= m;
    repeat (cyc) @(posedge pclk);
    gpio_event_in <= '0;
  endtask
endmodule
`default_nettype wire

// ==== sim/giis_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module giis_top_test
  import giis_pkg::*;
;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [GIIS_AW-1:0]   paddr = '0;
  logic [GIIS_DW-1:0]   pwdata = '0, prdata;
  logic                 pready, pslverr, irq, pin_reset_n = 1'b1, loader_valid = 1'b0;
  logic [GIIS_NPIN-1:0] gpio_event_in;
  logic [GIIS_NIND-1:0] indicator_enable_strap = 8'ha5, loader_ind_enable = '0, gpio_drive = '0;
  logic [GIIS_NIND-1:0] indicator_drive, pin_drive, indicator_pin_enable;
  logic [GIIS_FUNW-1:0] indicator_function_strap = 2'h2, loader_ind_function = '0, indicator_function_select;
  int                   n_errors = 0, checked = 0;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  giis_top giis_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .gpio_event_in, .pin_reset_n, .indicator_enable_strap, .indicator_function_strap,
    .loader_valid, .loader_ind_enable, .loader_ind_function, .gpio_drive, .indicator_drive, .pin_drive,
    .indicator_function_select, .indicator_pin_enable, .irq);
  giis_pin_model giis_pin_model_inst (.pclk, .indicator_function_select, .indicator_drive, .gpio_event_in);
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one bus transfer, bounded wait for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      $display("[FAIL] %0t bus hang", $time);
      tally_and_finish();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, '0, r, e);
    chk(r, x, m);
  endtask
  // reset values and strap capture
  task automatic t_reset();
    rd(GIIS_OFS_PIN_EVT, 32'h0, "event reset");
    rd(GIIS_OFS_IND_CFG, {22'h0, indicator_function_strap, indicator_enable_strap}, "straps");
    rd(GIIS_OFS_CHIP_STS, 32'h2, "strap flag");
    wr(GIIS_OFS_CHIP_STS, 32'h3);
  endtask
  // short and long events, enable, cascade, mask, clear
  task automatic t_event();
    giis_pin_model_inst.pulse(12'h008, 2);
    repeat (10) @(posedge pclk);
    rd(GIIS_OFS_PIN_EVT, 32'h0, "short pulse");
    giis_pin_model_inst.pulse(12'h008, 6);
    repeat (10) @(posedge pclk);
    rd(GIIS_OFS_PIN_EVT, 32'h8, "status no enable");
    rd(GIIS_OFS_CHIP_STS, 32'h0, "no cascade");
    wr(GIIS_OFS_PIN_EVT, 32'h0008_0000);
    rd(GIIS_OFS_PIN_EVT, 32'h0008_0008, "write zero keeps");
    rd(GIIS_OFS_CHIP_STS, 32'h1000, "cascade");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(GIIS_OFS_CHIP_EN, 32'h1000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(GIIS_OFS_PIN_EVT, 32'h0008_0008);
    rd(GIIS_OFS_PIN_EVT, 32'h0008_0000, "cleared");
    chk({31'h0, irq}, 32'h0, "irq off");
  endtask
  // reserved bits and an unmapped address
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    wr(GIIS_OFS_PIN_EVT, 32'hffff_ffff);
    rd(GIIS_OFS_PIN_EVT, 32'h0fff_0000, "event reserved");
    wr(GIIS_OFS_IND_CFG, 32'hffff_ffff);
    rd(GIIS_OFS_IND_CFG, 32'h3ff, "ind reserved");
    apb(12'h100, 1'b0, '0, r, e);
    chk({r[31:1], e}, 32'h1, "unmapped");
  endtask
  // pin routing and function code
  task automatic t_route();
    wr(GIIS_OFS_IND_CFG, 32'h20f);
    gpio_drive <= 8'h5c;
    repeat (3) @(posedge pclk);
    chk({24'h0, pin_drive}, 32'h5a, "route");
    chk({30'h0, indicator_function_select}, 32'h2, "function");
  endtask
  // loader overwrites the indicator fields
  task automatic t_load();
    @(posedge pclk);
    loader_valid <= 1'b1;
    loader_ind_enable <= 8'h81;
    loader_ind_function <= 2'h1;
    @(posedge pclk);
    loader_valid <= 1'b0;
    rd(GIIS_OFS_IND_CFG, 32'h181, "loader value");
    rd(GIIS_OFS_CHIP_STS, 32'h1, "loader flag");
  endtask
  // pin reset
  task automatic t_pin();
    pin_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_reset_n <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(GIIS_OFS_IND_CFG, 32'h2a5, "strap");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    t_reset();
    t_event();
    t_regs();
    t_route();
    t_load();
    t_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire
